// ==== hdl/bst_chain_if.sv ====
// link between the tap controller and the boundary chain
`timescale 1ns/1ps
`default_nettype none
interface bst_chain_if #(
  parameter int LEN = 8
);
  logic           capture;
  logic           shift;
  logic           update;
  logic           sin;
  logic           sout;
  logic [LEN-1:0] cap_data;
  logic [LEN-1:0] upd_data;

  modport ctrl (
    output capture, shift, update, sin, cap_data,
    input  sout, upd_data
  );
  modport chain (
    input  capture, shift, update, sin, cap_data,
    output sout, upd_data
  );
endinterface : bst_chain_if
`default_nettype wire

// ==== hdl/bst_pkg.sv ====
// constants and types of the boundary-scan test port
package bst_pkg;

  // instruction register
  localparam int          BST_IR_W       = 4;
  typedef logic [BST_IR_W-1:0] bst_ir_t;
  localparam bst_ir_t     BST_OP_EXTEST  = 4'h0;
  localparam bst_ir_t     BST_OP_IDCODE  = 4'h1;
  localparam bst_ir_t     BST_OP_SAMPLE  = 4'h2;
  localparam bst_ir_t     BST_OP_FRESET  = 4'hC;
  localparam bst_ir_t     BST_OP_BYPASS  = 4'hF;
  localparam bst_ir_t     BST_IR_CAPTURE = 4'h1;

  // identification register layout
  localparam int          BST_ID_W       = 32;
  localparam int          BST_VER_W      = 4;
  localparam int          BST_PART_W     = 16;
  localparam int          BST_MANUF_W    = 11;
  localparam logic        BST_ID_MARKER  = 1'b1;
  typedef logic [BST_ID_W-1:0] bst_id_t;

  // boundary cells per port pin, position inside each group
  localparam int          BST_CELLS_PIN  = 3;
  localparam int          BST_CELL_IN    = 0;
  localparam int          BST_CELL_DO    = 1;
  localparam int          BST_CELL_OE    = 2;

  // value captured into the bypass stage
  localparam logic        BST_BYP_CAP    = 1'b0;
  // asserting value of the reset data register
  localparam logic        BST_RST_ASSERT = 1'b1;

  typedef enum logic [3:0] {
    BST_TLR, BST_RTI,
    BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR,
    BST_PAU_DR, BST_EX2_DR, BST_UPD_DR,
    BST_SEL_IR, BST_CAP_IR, BST_SH_IR, BST_EX1_IR,
    BST_PAU_IR, BST_EX2_IR, BST_UPD_IR
  } bst_tap_t;

endpackage : bst_pkg

// ==== hdl/bst_scan_chain.sv ====
// boundary chain: shift stages and update latches
`timescale 1ns/1ps
`default_nettype none
module bst_scan_chain #(
  parameter int LEN = 8
) (
  // clock and reset
  input  wire logic    mclk,
  input  wire logic    arst_n,
  // control from the tap
  bst_chain_if.chain   ch
);
  import bst_pkg::*;

  logic [LEN-1:0] sh_r;
  logic [LEN-1:0] sh_nxt;
  logic [LEN-1:0] up_r;
  logic [LEN-1:0] up_nxt;

  always_comb begin
    sh_nxt = sh_r;
    up_nxt = up_r;
    if (ch.capture) begin
      sh_nxt = ch.cap_data;
    end else if (ch.shift) begin
      sh_nxt = {ch.sin, sh_r[LEN-1:1]};
    end
    if (ch.update) begin
      up_nxt = sh_r;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sh_r <= '0;
      up_r <= '0;
    end else begin
      sh_r <= sh_nxt;
      up_r <= up_nxt;
    end
  end

  assign ch.sout     = sh_r[0];
  assign ch.upd_data = up_r;

endmodule // bst_scan_chain
`default_nettype wire

// ==== hdl/bst_test_port.sv ====
// boundary-scan test access port with its data registers
// Notes on behaviour
// - after power-up the instruction register selects the id register
// - instructions bypass, sample/preload, extest, idcode and force-reset
// - entering device reset puts every port pin output into high impedance, except under extest
// - device reset from low reset pin or force-reset with reset bit set
// - extest drives output latches onto pins as soon as it is loaded
// - sample/preload snapshots pins without disturbing normal operation
// - port works only with enable fuse programmed and disable bit cleared
// - works with test clock faster than chip clock, or chip clock stopped; here tck is sampled on mclk, which must keep running and be faster than tck
// - data registers: bypass, identification, reset register, boundary chain
// - chain covers all port pin functions and analog interface signals
// - bypass gives the shortest serial path from data in to data out
// - access uses only the four test port signals
// - four-bit instruction register, opcodes 0, 1, 2, C and F
// - every shift register shifts least significant bit first
// - bypass stage loads zero in the capture state
// - reset register output unlatched: a one holds device reset immediately
`timescale 1ns/1ps
`default_nettype none
module bst_test_port #(
  parameter int                    NPINS      = 8,
  parameter int                    NANA       = 2,
  parameter logic [3:0]            ID_VERSION = 4'h0,    // arbitrary value
  parameter logic [15:0]           ID_PART    = 16'h00A5, // arbitrary value
  parameter logic [10:0]           ID_MANUF   = 11'h055   // arbitrary value
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                arst_n,
  // test access pins
  input  wire logic                tck,
  input  wire logic                tms,
  input  wire logic                tdi,
  output logic                     tdo,
  output logic                     tdo_oe,
  // enables
  input  wire logic                test_port_enable_fuse,
  input  wire logic                test_port_disable_bit,
  // external reset pin and resulting device reset
  input  wire logic                ext_reset_n,
  output logic                     device_reset,
  // core side of the port pins
  input  wire logic [NPINS-1:0]    core_out,
  input  wire logic [NPINS-1:0]    core_oe,
  output logic [NPINS-1:0]         core_in,
  // pad side of the port pins
  input  wire logic [NPINS-1:0]    pad_in,
  output logic [NPINS-1:0]         pad_out,
  output logic [NPINS-1:0]         pad_oe,
  // digital to analog interface
  input  wire logic [NANA-1:0]     ana_core,
  output logic [NANA-1:0]          ana_out
);
  import bst_pkg::*;

  localparam int LEN = BST_CELLS_PIN * NPINS + NANA;

  // two-flop synchronisers for pins: {ext_reset_n, tdi, tms, tck}
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [NPINS-1:0] p1_r;
  logic [NPINS-1:0] p2_r;
  logic tck_d_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // idle pin levels, tck low: no false tck edge after reset
      s1_r    <= 4'hA;
      s2_r    <= 4'hA;
      p1_r    <= '0;
      p2_r    <= '0;
      tck_d_r <= 1'b0;
    end else begin
      s1_r    <= {ext_reset_n, tdi, tms, tck};
      s2_r    <= s1_r;
      p1_r    <= pad_in;
      p2_r    <= p1_r;
      tck_d_r <= s2_r[0];
    end
  end

  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic extrst_n_s;
  logic tck_rise;
  logic tck_fall;
  logic port_en;

  assign tck_s      = s2_r[0];
  assign tms_s      = s2_r[1];
  assign tdi_s      = s2_r[2];
  assign extrst_n_s = s2_r[3];
  // edges of the test clock; mclk need not relate to any chip clock
  assign tck_rise   = tck_s & ~tck_d_r;
  assign tck_fall   = ~tck_s & tck_d_r;
  assign port_en    = test_port_enable_fuse & ~test_port_disable_bit;

  // tap state machine, stepped on test clock rising edges
  bst_tap_t st_r;
  bst_tap_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!port_en) begin
      st_nxt = BST_TLR;
    end else if (tck_rise) begin
      unique case (st_r)
        BST_TLR:    st_nxt = tms_s ? BST_TLR    : BST_RTI;
        BST_RTI:    st_nxt = tms_s ? BST_SEL_DR : BST_RTI;
        BST_SEL_DR: st_nxt = tms_s ? BST_SEL_IR : BST_CAP_DR;
        BST_CAP_DR: st_nxt = tms_s ? BST_EX1_DR : BST_SH_DR;
        BST_SH_DR:  st_nxt = tms_s ? BST_EX1_DR : BST_SH_DR;
        BST_EX1_DR: st_nxt = tms_s ? BST_UPD_DR : BST_PAU_DR;
        BST_PAU_DR: st_nxt = tms_s ? BST_EX2_DR : BST_PAU_DR;
        BST_EX2_DR: st_nxt = tms_s ? BST_UPD_DR : BST_SH_DR;
        BST_UPD_DR: st_nxt = tms_s ? BST_SEL_DR : BST_RTI;
        BST_SEL_IR: st_nxt = tms_s ? BST_TLR    : BST_CAP_IR;
        BST_CAP_IR: st_nxt = tms_s ? BST_EX1_IR : BST_SH_IR;
        BST_SH_IR:  st_nxt = tms_s ? BST_EX1_IR : BST_SH_IR;
        BST_EX1_IR: st_nxt = tms_s ? BST_UPD_IR : BST_PAU_IR;
        BST_PAU_IR: st_nxt = tms_s ? BST_EX2_IR : BST_PAU_IR;
        BST_EX2_IR: st_nxt = tms_s ? BST_UPD_IR : BST_SH_IR;
        BST_UPD_IR: st_nxt = tms_s ? BST_SEL_DR : BST_RTI;
      endcase
    end
  end

  // instruction and data registers
  bst_ir_t              ir_r;
  bst_ir_t              ir_nxt;
  bst_ir_t              irsh_r;
  bst_ir_t              irsh_nxt;
  logic                 byp_r;
  logic                 byp_nxt;
  bst_id_t              id_r;
  bst_id_t              id_nxt;
  logic                 rst_r;
  logic                 rst_nxt;
  logic                 tdo_nxt;
  logic                 tdo_oe_nxt;
  bst_id_t              id_value;
  logic                 cap_dr;
  logic                 sh_dr;
  logic                 is_bsc;

  assign id_value = {ID_VERSION, ID_PART, ID_MANUF, BST_ID_MARKER};
  assign cap_dr   = tck_rise & (st_r == BST_CAP_DR);
  assign sh_dr    = tck_rise & (st_r == BST_SH_DR);
  assign is_bsc   = (ir_r == BST_OP_EXTEST) || (ir_r == BST_OP_SAMPLE);

  bst_chain_if #(.LEN(LEN)) chn ();

  always_comb begin
    ir_nxt     = ir_r;
    irsh_nxt   = irsh_r;
    byp_nxt    = byp_r;
    id_nxt     = id_r;
    rst_nxt    = rst_r;
    tdo_nxt    = tdo;
    tdo_oe_nxt = tdo_oe;
    if (st_r == BST_TLR) begin
      ir_nxt  = BST_OP_IDCODE;
      rst_nxt = ~BST_RST_ASSERT;
    end else begin
      if (tck_rise && st_r == BST_CAP_IR) begin
        irsh_nxt = BST_IR_CAPTURE;
      end
      if (tck_rise && st_r == BST_SH_IR) begin
        irsh_nxt = {tdi_s, irsh_r[BST_IR_W-1:1]};
      end
      if (tck_fall && st_r == BST_UPD_IR) begin
        ir_nxt = irsh_r;
      end
      unique case (ir_r)
        BST_OP_IDCODE: begin
          if (cap_dr) id_nxt = id_value;
          if (sh_dr)  id_nxt = {tdi_s, id_r[BST_ID_W-1:1]};
        end
        BST_OP_FRESET: begin
          if (sh_dr) rst_nxt = tdi_s;
        end
        BST_OP_EXTEST, BST_OP_SAMPLE: begin
        end
        default: begin
          if (cap_dr) byp_nxt = BST_BYP_CAP;
          if (sh_dr)  byp_nxt = tdi_s;
        end
      endcase
    end
    // serial output changes on the falling test clock edge
    if (tck_fall) begin
      tdo_oe_nxt = (st_r == BST_SH_IR) || (st_r == BST_SH_DR);
      if (st_r == BST_SH_IR) begin
        tdo_nxt = irsh_r[0];
      end else if (st_r == BST_SH_DR) begin
        unique case (ir_r)
          BST_OP_IDCODE:                tdo_nxt = id_r[0];
          BST_OP_FRESET:                tdo_nxt = rst_r;
          BST_OP_EXTEST, BST_OP_SAMPLE: tdo_nxt = chn.sout;
          default:                      tdo_nxt = byp_r;
        endcase
      end
    end
    if (!port_en) begin
      tdo_oe_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r   <= BST_TLR;
      ir_r   <= BST_OP_IDCODE;
      irsh_r <= BST_IR_CAPTURE;
      byp_r  <= BST_BYP_CAP;
      id_r   <= '0;
      rst_r  <= ~BST_RST_ASSERT;
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      ir_r   <= ir_nxt;
      irsh_r <= irsh_nxt;
      byp_r  <= byp_nxt;
      id_r   <= id_nxt;
      rst_r  <= rst_nxt;
      tdo    <= tdo_nxt;
      tdo_oe <= tdo_oe_nxt;
    end
  end

  // boundary chain: capture values from pins and core drive
  logic [LEN-1:0] cap_vec;

  always_comb begin
    cap_vec = '0;
    for (int i = 0; i < NPINS; i++) begin
      cap_vec[BST_CELLS_PIN*i + BST_CELL_IN] = p2_r[i];
      cap_vec[BST_CELLS_PIN*i + BST_CELL_DO] = core_out[i];
      cap_vec[BST_CELLS_PIN*i + BST_CELL_OE] = core_oe[i];
    end
    for (int j = 0; j < NANA; j++) begin
      cap_vec[BST_CELLS_PIN*NPINS + j] = ana_core[j];
    end
  end

  assign chn.capture  = cap_dr & is_bsc;
  assign chn.shift    = sh_dr & is_bsc;
  assign chn.update   = tck_fall & (st_r == BST_UPD_DR) & is_bsc;
  assign chn.sin      = tdi_s;
  assign chn.cap_data = cap_vec;

  bst_scan_chain #(.LEN(LEN)) u_chain (
    .mclk   (mclk),
    .arst_n (arst_n),
    .ch     (chn.chain)
  );

  // pin and reset drive, all registered
  logic             extest_on;
  logic             dev_rst_nxt;
  logic [NPINS-1:0] pad_out_nxt;
  logic [NPINS-1:0] pad_oe_nxt;
  logic [NANA-1:0]  ana_nxt;

  assign extest_on = port_en & (ir_r == BST_OP_EXTEST);

  always_comb begin
    // reset register bit acts directly, tap is not reset
    dev_rst_nxt = ~extrst_n_s
                | (port_en & (ir_r == BST_OP_FRESET)
                   & (rst_r == BST_RST_ASSERT));
    pad_out_nxt = core_out;
    pad_oe_nxt  = device_reset ? '0 : core_oe;
    ana_nxt     = ana_core;
    if (extest_on) begin
      for (int i = 0; i < NPINS; i++) begin
        pad_out_nxt[i] = chn.upd_data[BST_CELLS_PIN*i + BST_CELL_DO];
        pad_oe_nxt[i]  = chn.upd_data[BST_CELLS_PIN*i + BST_CELL_OE];
      end
      for (int j = 0; j < NANA; j++) begin
        ana_nxt[j] = chn.upd_data[BST_CELLS_PIN*NPINS + j];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      device_reset <= 1'b1;
      pad_out      <= '0;
      pad_oe       <= '0;
      ana_out      <= '0;
      core_in      <= '0;
    end else begin
      device_reset <= dev_rst_nxt;
      pad_out      <= pad_out_nxt;
      pad_oe       <= pad_oe_nxt;
      ana_out      <= ana_nxt;
      core_in      <= p2_r;
    end
  end

endmodule // bst_test_port
`default_nettype wire

// ==== tb/bst_port_properties.sv ====
// assertions on the ports of the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module bst_port_properties #(
  parameter int NPINS = 8
) (
  // clock and reset
  input wire logic             mclk,
  input wire logic             arst_n,
  // test pins and enables
  input wire logic             tck,
  input wire logic             tdo,
  input wire logic             tdo_oe,
  input wire logic             test_port_enable_fuse,
  input wire logic             test_port_disable_bit,
  // reset
  input wire logic             ext_reset_n,
  input wire logic             device_reset,
  // port pins
  input wire logic [NPINS-1:0] core_out,
  input wire logic [NPINS-1:0] core_oe,
  input wire logic [NPINS-1:0] core_in,
  input wire logic [NPINS-1:0] pad_in,
  input wire logic [NPINS-1:0] pad_out,
  input wire logic [NPINS-1:0] pad_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  logic off;
  assign off = !test_port_enable_fuse || test_port_disable_bit;
  sequence off_s;
    off [*4];
  endsequence
  sequence ext_low_s;
    !ext_reset_n [*4];
  endsequence
  port_off_a: assert property (off_s |-> !tdo_oe)
    else $error("tdo driven while port off");
  no_freset_a: assert property (
    (off && ext_reset_n) [*5] |-> !device_reset)
    else $error("device reset while port off");
  ext_rst_a: assert property (ext_low_s |-> device_reset)
    else $error("external reset not seen");
  rst_rel_a: assert property (
    $fell(device_reset) |-> $past(ext_reset_n, 3))
    else $error("reset released while pin low");
  reset_hiz_a: assert property (
    (off && device_reset) [*4] |-> pad_oe == '0)
    else $error("pins driven in reset");
  pin_pass_a: assert property (
    (off && !device_reset) [*4] ##0 $stable({core_out, core_oe})
    |-> pad_out == core_out && pad_oe == core_oe)
    else $error("pins not from core");
  core_in_a: assert property ($stable(pad_in) [*5] |-> core_in == pad_in)
    else $error("pin levels not passed to core");
  tdo_edge_a: assert property ($changed(tdo) |-> !tck)
    else $error("tdo changed while tck high");
endmodule // bst_port_properties

bind bst_test_port bst_port_properties #(.NPINS(NPINS)) i_props (
  .mclk(mclk), .arst_n(arst_n), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe),
  .test_port_enable_fuse(test_port_enable_fuse),
  .test_port_disable_bit(test_port_disable_bit),
  .ext_reset_n(ext_reset_n), .device_reset(device_reset),
  .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
  .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe)
);
`default_nettype wire

// ==== tb/bst_tap_model.sv ====
// test controller model for the four-pin test port
`timescale 1ns/1ps
`default_nettype none
module bst_tap_model (
  // test pins
  output logic     tck,
  output logic     tms,
  output logic     tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one tck period, tdo taken just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #81;
    q = tdo;
    tck = 1'b1;
    #79;
    tck = 1'b0;
  endtask
  // idle to shift state, n bits lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule // bst_tap_model
`default_nettype wire

// ==== tb/tb_boundary_scan_test_port.sv ====
// self-checking bench of the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module tb_boundary_scan_test_port;
  import bst_pkg::*;
  localparam int          NP   = 8;
  localparam int          NA   = 2;
  localparam int          CL   = 3 * NP + NA;
  localparam logic [3:0]  VER  = 4'h3;    // arbitrary value
  localparam logic [15:0] PART = 16'h5a3c; // arbitrary value
  localparam logic [10:0] MANF = 11'h2a5;  // arbitrary value
  logic          mclk = 1'b0;
  logic          arst_n = 1'b0;
  logic          test_port_enable_fuse = 1'b1;
  logic          test_port_disable_bit = 1'b0;
  logic          ext_reset_n = 1'b1;
  logic [NP-1:0] core_out = '0, core_oe = '0, pad_in = '0;
  logic [NA-1:0] ana_core = '0;
  logic          tck, tms, tdi, tdo, tdo_oe, device_reset;
  logic [NP-1:0] core_in, pad_out, pad_oe;
  logic [NA-1:0] ana_out;
  logic [63:0]   exp_q[$];
  logic [63:0]   res_v;
  event          res_ev;
  int            n_errors = 0;
  int            checks = 0;
  always #2.5 mclk = ~mclk;
  bst_test_port #(.NPINS(NP), .NANA(NA), .ID_VERSION(VER), .ID_PART(PART),
    .ID_MANUF(MANF)) i_dut (
    .mclk(mclk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe),
    .test_port_enable_fuse(test_port_enable_fuse),
    .test_port_disable_bit(test_port_disable_bit),
    .ext_reset_n(ext_reset_n), .device_reset(device_reset),
    .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .ana_core(ana_core), .ana_out(ana_out));
  bst_tap_model i_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  task automatic check(input logic [63:0] v, input logic [63:0] e);
    checks++;
    if (v !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, v, e);
    end
  endtask
  always @(res_ev) check(res_v, exp_q.pop_front());
  task automatic note(input logic [63:0] e);
    exp_q.push_back(e);
  endtask
  task automatic seen(input logic [63:0] v);
    res_v = v;
    ->res_ev;
    #1;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic ir(input bst_ir_t op);
    logic [63:0] q;
    i_ctl.scan(1'b1, BST_IR_W, 64'(op), q);
    note(64'h1);
    seen(q);
  endtask
  function automatic logic [CL-1:0] capv();
    capv = {ana_core, {(3 * NP){1'b0}}};
    for (int i = 0; i < NP; i++)
      capv[3*i +: 3] = {core_oe[i], core_out[i], pad_in[i]};
  endfunction
  function automatic logic [NP-1:0] pick(input logic [CL-1:0] v, int k);
    for (int i = 0; i < NP; i++)
      pick[i] = v[3*i+k];
  endfunction
  task automatic complete_run();
    if (exp_q.size() != 0) n_errors++;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400us;
    n_errors++;
    complete_run();
  end
  initial begin
    logic [63:0]   q;
    logic [CL-1:0] pre;
    logic          b;
    int            s;
    s = $urandom(77260);
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    settle(4);
    i_ctl.step(1'b0, 1'b0, b);
    i_ctl.scan(1'b0, BST_ID_W, '0, q);
    note({32'h0, VER, PART, MANF, 1'b1});
    seen(q);
    $display("test idcode done");
    ir(BST_OP_BYPASS);
    pre = CL'($urandom);
    i_ctl.scan(1'b0, 8, 64'(pre), q);
    note({56'h0, pre[6:0], 1'b0});
    seen(q);
    $display("test bypass done");
    @(posedge mclk);
    {pad_in, core_out, core_oe, ana_core} <= CL'($urandom);
    settle(6);
    pre = CL'({$urandom, $urandom});
    ir(BST_OP_SAMPLE);
    i_ctl.scan(1'b0, CL, 64'(pre), q);
    note(64'(capv()));
    seen(q);
    note(64'({core_oe, core_out}));
    seen(64'({pad_oe, pad_out}));
    $display("test sample done");
    ir(BST_OP_EXTEST);
    settle(4);
    note(64'({pre[CL-1 -: NA], pick(pre, 2), pick(pre, 1)}));
    seen(64'({ana_out, pad_oe, pad_out}));
    $display("test extest done");
    ir(BST_OP_FRESET);
    i_ctl.scan(1'b0, 1, 64'h1, q);
    settle(4);
    note(64'({1'b1, 8'h0}));
    seen(64'({device_reset, pad_oe}));
    ir(BST_OP_FRESET);
    i_ctl.scan(1'b0, 1, 64'h0, q);
    settle(4);
    note(64'h0);
    seen(64'(device_reset));
    $display("test force reset done");
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      test_port_enable_fuse <= i[0];
      test_port_disable_bit <= i[0];
      ext_reset_n <= 1'b0;
      settle(6);
      note(64'h1);
      seen(64'(device_reset));
      @(posedge mclk);
      ext_reset_n <= 1'b1;
      i_ctl.scan(1'b1, BST_IR_W, 64'(BST_OP_FRESET), q);
      i_ctl.scan(1'b0, 1, 64'h1, q);
      settle(4);
      note(64'h0);
      seen(64'(device_reset));
    end
    $display("test port disable done");
    complete_run();
  end
endmodule // tb_boundary_scan_test_port
`default_nettype wire
